// >>> fbe_pkg.sv
// Shared constants and types for the flash burst read engine
// Notes on behaviour
// RQ1: Powers up in asynchronous read mode only.
// RQ2: Host sets wait, mode, edge, ready first.
// RQ3: After configuration only synchronous reads answered.
// RQ4: First word after wait, then one per edge.
// RQ5: Every 64-word block end is a boundary.
// RQ6: Block crossing adds two, slow variant three.
// RQ7: Odd start waits once at first 16-crossing.
// RQ8: Odd start in top sixteen adds three.
// RQ9: Slow variant host adds one more wait.
// RQ10: Ready held low during added cycles.
// RQ11: Continuous burst wraps; stops on CE, reset, load.
// RQ12: Idle bank crossing adds the two-cycle gap.
// RQ13: Busy bank crossing shows status, ignores clock.
// RQ14: Host restarts with new address after status.
// RQ15: Wrap groups of 8/16/32, size aligned.
// RQ16: Wrap counts up, returns to group start.
// RQ17: Wrap modes add no boundary waits.
// RQ18: Ready shows valid word each cycle.
// RQ19: Configuration holds wait, mode, edge, ready, sync.
// RQ20: First word marked by ready after OE.
// RQ21: Host matches wait count to clock rate.
// RQ22: Reads in idle bank with no penalty.
// RQ23: Suspended erase bank readable except erasing sector.
// RQ24: Rising edge active unless configured otherwise.
// RQ25: Load needs CE low, WE high, address valid.
// RQ26: Pin reset returns to async mode, ends burst.
// RQ27: Counter full width; wrap touches group bits only.
package fbe_pkg;
    // Widths
    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;
    localparam int WAIT_W = 4;
    localparam int BANK_W = 2;
    localparam int SECT_LSB = 15;
    localparam int SECT_W = ADDR_W - SECT_LSB;
    // Boundary field positions
    localparam int BLK_W = 6;
    localparam int GRP16_W = 4;
    localparam int GRP_W = 5;
    // Wrap group masks
    localparam logic [GRP_W-1:0] MASK_W8 = 5'h07;
    localparam logic [GRP_W-1:0] MASK_W16 = 5'h0f;
    localparam logic [GRP_W-1:0] MASK_W32 = 5'h1f;
    // Added cycles at boundaries
    localparam logic [1:0] GAP_NONE = 2'h0;
    localparam logic [1:0] GAP_ODD16 = 2'h1;
    localparam logic [1:0] GAP_STD = 2'h2;
    localparam logic [1:0] GAP_SLOW = 2'h3;
    localparam logic [1:0] GAP_ODD64 = 2'h3;
    // Pin bundle positions and idle value
    localparam int PIN_CLK = 0;
    localparam int PIN_CE = 1;
    localparam int PIN_OE = 2;
    localparam int PIN_WE = 3;
    localparam int PIN_AVD = 4;
    localparam int PIN_RST = 5;
    localparam int PIN_W = 6;
    localparam logic [PIN_W-1:0] PIN_IDLE = 6'h3e;
    // Configuration reset values
    localparam logic [WAIT_W-1:0] WAIT_RST = 4'h5;
    // Read pipeline depth from state to pins
    localparam int PIPE_DEPTH = 3;
    // Burst modes
    typedef enum logic [1:0] {
        FBE_CONT = 2'h0,
        FBE_WRAP8 = 2'h1,
        FBE_WRAP16 = 2'h2,
        FBE_WRAP32 = 2'h3
    } fbe_mode_t;
    // Burst states, Gray along idle-init-data-gap-status
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_INIT = 3'h1,
        ST_DATA = 3'h3,
        ST_GAP = 3'h2,
        ST_STAT = 3'h6
    } fbe_state_t;
endpackage : fbe_pkg

// >>> fbe_step_if.sv
// Link between burst control and the address step logic
`timescale 1ns/1ps
interface fbe_step_if;
    logic [fbe_pkg::ADDR_W-1:0] cur_addr; // Word now on the bus
    fbe_pkg::fbe_mode_t mode; // Burst mode
    logic start_odd; // Burst began on odd word
    logic first16_open; // No 16-word crossing yet
    logic slow; // Slow variant
    logic [fbe_pkg::ADDR_W-1:0] next_addr; // Following word
    logic [1:0] gap; // Added cycles before it
    logic cross16; // Step crosses a 16-word line
    modport ctrl (
        output cur_addr, mode, start_odd, first16_open, slow,
        input next_addr, gap, cross16
    );
    modport step (
        input cur_addr, mode, start_odd, first16_open, slow,
        output next_addr, gap, cross16
    );
endinterface : fbe_step_if

// >>> fbe_addr_step.sv
// Next burst address and boundary wait count
`timescale 1ns/1ps
module fbe_addr_step (
    // Step link
    fbe_step_if.step s
);
    logic [fbe_pkg::ADDR_W-1:0] inc_addr; // Plain increment
    logic [fbe_pkg::ADDR_W-1:0] wrap_mask; // Bits that wrap
    logic [fbe_pkg::ADDR_W-1:0] wrap_addr; // Group-wrapped step
    logic [fbe_pkg::GRP_W-1:0] grp_mask; // Group size mask
    logic cont; // Continuous mode
    logic blk_end; // Last word of 64 block
    logic g16_end; // Last word of 16 group
    logic odd_open; // Odd start still pending
    // Full-width counter rolls past the top to zero
    assign inc_addr = s.cur_addr + {{(fbe_pkg::ADDR_W-1){1'b0}}, 1'b1}; // RQ11
    // Group mask picks the aligned wrap group
    assign grp_mask = (s.mode == fbe_pkg::FBE_WRAP8) ? fbe_pkg::MASK_W8 :
        (s.mode == fbe_pkg::FBE_WRAP16) ? fbe_pkg::MASK_W16 :
        (s.mode == fbe_pkg::FBE_WRAP32) ? fbe_pkg::MASK_W32 : '0; // RQ15
    assign wrap_mask = {{(fbe_pkg::ADDR_W-fbe_pkg::GRP_W){1'b0}}, grp_mask};
    // Upper bits held, low group bits roll over
    assign wrap_addr = (s.cur_addr & ~wrap_mask) | (inc_addr & wrap_mask); // RQ16 RQ27
    assign cont = (s.mode == fbe_pkg::FBE_CONT);
    assign s.next_addr = cont ? inc_addr : wrap_addr;
    // Boundary detection on the word being left
    assign blk_end = &s.cur_addr[fbe_pkg::BLK_W-1:0]; // RQ5
    assign g16_end = &s.cur_addr[fbe_pkg::GRP16_W-1:0];
    assign odd_open = s.start_odd & s.first16_open;
    assign s.cross16 = cont & g16_end;
    // Wrap modes never cross, so they never wait
    assign s.gap = !cont ? fbe_pkg::GAP_NONE : // RQ17
        (blk_end && odd_open) ? fbe_pkg::GAP_ODD64 : // RQ8
        blk_end ? (s.slow ? fbe_pkg::GAP_SLOW : fbe_pkg::GAP_STD) : // RQ6 RQ12
        (g16_end && odd_open) ? fbe_pkg::GAP_ODD16 : fbe_pkg::GAP_NONE; // RQ7
endmodule : fbe_addr_step

// >>> fbe_burst_read.sv
// Burst read engine of a multi-bank NOR flash
`timescale 1ns/1ps
module fbe_burst_read #(
    parameter bit SLOW_VARIANT = 1'b0,
    parameter int NBANK = 4
) (
    // System clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Host pins, asynchronous to clk_sys_in
    input wire logic flash_clk_in,
    input wire logic chip_sel_n_in,
    input wire logic out_en_n_in,
    input wire logic write_en_n_in,
    input wire logic address_valid_n_in,
    input wire logic flash_rst_n_in,
    input wire logic [fbe_pkg::ADDR_W-1:0] addr_in,
    // Data and ready pins
    output logic [fbe_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe_out,
    output logic ready_out,
    output logic ready_oe_out,
    // Configuration from the command decoder
    input wire logic cfg_load_in,
    input wire logic [fbe_pkg::WAIT_W-1:0] cfg_wait_in,
    input wire logic [1:0] cfg_mode_in,
    input wire logic cfg_falling_in,
    input wire logic cfg_rdy_early_in,
    input wire logic cfg_sync_en_in,
    // Array read port, one cycle latency
    output logic [fbe_pkg::ADDR_W-1:0] array_addr_out,
    input wire logic [fbe_pkg::DATA_W-1:0] array_data_in,
    // Program and erase engine state
    input wire logic [NBANK-1:0] bank_busy_in,
    input wire logic [NBANK-1:0] bank_susp_in,
    input wire logic [fbe_pkg::SECT_W-1:0] susp_sector_in,
    input wire logic [fbe_pkg::DATA_W-1:0] status_in,
    // Mode status
    output logic sync_mode_out,
    output logic burst_active_out
);
    localparam int AW = fbe_pkg::ADDR_W;
    localparam int SYNC_W = fbe_pkg::PIN_W + AW;

    // Pin synchroniser, two stages
    logic [SYNC_W-1:0] pin_meta; // First stage, read only by pin_sync
    logic [SYNC_W-1:0] pin_sync; // Second stage
    logic lclk_prev; // Link clock one sample back
    // Decoded synchronised pins
    logic lclk;
    logic ce_on;
    logic oe_on;
    logic we_off;
    logic avd_on;
    logic pin_rst_n;
    logic [AW-1:0] addr_s;
    logic act_edge; // Active link clock edge seen
    logic load_hit; // Burst address load this edge
    // Configuration register
    logic [fbe_pkg::WAIT_W-1:0] cfg_wait;
    fbe_pkg::fbe_mode_t cfg_mode;
    logic cfg_falling;
    logic cfg_rdy_early;
    logic sync_mode;
    // Burst state
    fbe_pkg::fbe_state_t st;
    fbe_pkg::fbe_state_t next_st;
    logic [AW-1:0] burst_addr;
    logic [fbe_pkg::WAIT_W-1:0] init_cnt;
    logic [1:0] gap_cnt;
    logic start_odd;
    logic first16_open;
    // Asynchronous read path
    logic [AW-1:0] async_addr;
    logic async_sel;
    // Bank access checks
    logic [fbe_pkg::BANK_W-1:0] next_bank;
    logic [fbe_pkg::BANK_W-1:0] load_bank;
    logic next_ok;
    logic load_ok;
    // Ready pipeline, aligned with the array read
    logic valid_now;
    logic rdy_d1;
    logic rdy_d2;
    logic stat_d1;

    fbe_step_if step_link ();

    // Address step and boundary logic
    fbe_addr_step u_step (
        .s(step_link.step)
    );

    // Two-stage sampling of every host pin
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            pin_meta <= {{AW{1'b0}}, fbe_pkg::PIN_IDLE};
            pin_sync <= {{AW{1'b0}}, fbe_pkg::PIN_IDLE};
            lclk_prev <= 1'b0;
        end else begin
            pin_meta <= {addr_in, flash_rst_n_in, address_valid_n_in, write_en_n_in,
                out_en_n_in, chip_sel_n_in, flash_clk_in};
            pin_sync <= pin_meta;
            lclk_prev <= pin_sync[fbe_pkg::PIN_CLK];
        end
    end

    // Pin decode from the second stage only
    assign lclk = pin_sync[fbe_pkg::PIN_CLK];
    assign ce_on = !pin_sync[fbe_pkg::PIN_CE];
    assign oe_on = !pin_sync[fbe_pkg::PIN_OE];
    assign we_off = pin_sync[fbe_pkg::PIN_WE];
    assign avd_on = !pin_sync[fbe_pkg::PIN_AVD];
    assign pin_rst_n = pin_sync[fbe_pkg::PIN_RST];
    assign addr_s = pin_sync[SYNC_W-1:fbe_pkg::PIN_W];
    // Rising edge unless configured for falling
    assign act_edge = cfg_falling ? (lclk_prev & !lclk) : (!lclk_prev & lclk); // RQ24
    // Address load needs CE low, WE high, address valid
    assign load_hit = act_edge & ce_on & we_off & avd_on; // RQ25

    // Configuration register, cleared by either reset
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || !pin_rst_n) begin
            cfg_wait <= fbe_pkg::WAIT_RST;
            cfg_mode <= fbe_pkg::FBE_CONT;
            cfg_falling <= 1'b0;
            cfg_rdy_early <= 1'b0;
            sync_mode <= 1'b0; // RQ1 RQ26
        end else if (cfg_load_in) begin
            // All five fields stored together
            cfg_wait <= cfg_wait_in; // RQ19
            cfg_mode <= fbe_pkg::fbe_mode_t'(cfg_mode_in);
            cfg_falling <= cfg_falling_in;
            cfg_rdy_early <= cfg_rdy_early_in;
            sync_mode <= cfg_sync_en_in; // RQ3
        end
    end

    // Bank of the next word and of a loaded address
    assign next_bank = step_link.next_addr[AW-1 -: fbe_pkg::BANK_W];
    assign load_bank = addr_s[AW-1 -: fbe_pkg::BANK_W];
    // Busy bank readable only while suspended, outside the erasing sector
    assign next_ok = !bank_busy_in[next_bank] || (bank_susp_in[next_bank] &&
        step_link.next_addr[AW-1:fbe_pkg::SECT_LSB] != susp_sector_in); // RQ22 RQ23
    assign load_ok = !bank_busy_in[load_bank] || (bank_susp_in[load_bank] &&
        addr_s[AW-1:fbe_pkg::SECT_LSB] != susp_sector_in); // RQ22 RQ23

    // Step link inputs
    assign step_link.cur_addr = burst_addr;
    assign step_link.mode = cfg_mode;
    assign step_link.start_odd = start_odd;
    assign step_link.first16_open = first16_open;
    assign step_link.slow = SLOW_VARIANT;

    // Next burst state
    always_comb begin
        next_st = st;
        if (!ce_on || !sync_mode) begin
            next_st = fbe_pkg::ST_IDLE; // RQ11
        end else if (load_hit) begin
            // A new address restarts from any state
            next_st = load_ok ? fbe_pkg::ST_INIT : fbe_pkg::ST_STAT; // RQ14
        end else if (act_edge) begin
            unique case (st)
                fbe_pkg::ST_IDLE: next_st = fbe_pkg::ST_IDLE;
                fbe_pkg::ST_INIT: begin
                    if (init_cnt == '0) begin
                        next_st = fbe_pkg::ST_DATA; // RQ4
                    end
                end
                fbe_pkg::ST_DATA: begin
                    if (!next_ok) begin
                        next_st = fbe_pkg::ST_STAT; // RQ13
                    end else if (step_link.gap != fbe_pkg::GAP_NONE) begin
                        next_st = fbe_pkg::ST_GAP; // RQ6
                    end
                end
                fbe_pkg::ST_GAP: begin
                    if (gap_cnt == 2'h1) begin
                        next_st = fbe_pkg::ST_DATA;
                    end
                end
                // Clock ignored until a fresh load
                fbe_pkg::ST_STAT: next_st = fbe_pkg::ST_STAT; // RQ13
                default: next_st = fbe_pkg::ST_IDLE;
            endcase
        end
    end

    // State register, pin reset ends any burst
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || !pin_rst_n) begin
            st <= fbe_pkg::ST_IDLE; // RQ26
        end else begin
            st <= next_st;
        end
    end

    // Address counter and wait counters
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            burst_addr <= '0;
            init_cnt <= '0;
            gap_cnt <= '0;
            start_odd <= 1'b0;
            first16_open <= 1'b0;
        end else if (load_hit) begin
            burst_addr <= addr_s;
            init_cnt <= cfg_wait; // RQ4
            gap_cnt <= '0;
            start_odd <= addr_s[0];
            first16_open <= 1'b1;
        end else if (act_edge && st == fbe_pkg::ST_INIT && init_cnt != '0) begin
            init_cnt <= init_cnt - 1'b1;
        end else if (act_edge && st == fbe_pkg::ST_DATA && next_ok) begin
            // One word per edge, gap loaded on crossings
            burst_addr <= step_link.next_addr; // RQ4 RQ16
            gap_cnt <= step_link.gap; // RQ10
            if (step_link.cross16) begin
                first16_open <= 1'b0; // RQ7
            end
        end else if (act_edge && st == fbe_pkg::ST_GAP) begin
            gap_cnt <= gap_cnt - 1'b1;
        end
    end

    // Asynchronous reads, answered only while sync mode is off
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || !pin_rst_n) begin
            async_addr <= '0;
            async_sel <= 1'b0;
        end else if (sync_mode || !ce_on) begin
            async_sel <= 1'b0; // RQ3
        end else if (avd_on && we_off) begin
            async_addr <= addr_s; // RQ1
            async_sel <= 1'b1;
        end
    end

    // Valid word now, or one edge early when configured
    assign valid_now = (st == fbe_pkg::ST_DATA) ||
        (cfg_rdy_early && st == fbe_pkg::ST_INIT && init_cnt == '0) ||
        (cfg_rdy_early && st == fbe_pkg::ST_GAP && gap_cnt == 2'h1); // RQ18

    // Array address and ready pipeline
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            array_addr_out <= '0;
            rdy_d1 <= 1'b0;
            rdy_d2 <= 1'b0;
            stat_d1 <= 1'b0;
        end else begin
            array_addr_out <= sync_mode ? burst_addr : async_addr;
            rdy_d1 <= valid_now;
            rdy_d2 <= rdy_d1;
            stat_d1 <= (st == fbe_pkg::ST_STAT);
        end
    end

    // Pin drivers: array data and ready three cycles behind the state, status data two, enables one
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            dq_out <= '0;
            dq_oe_out <= 1'b0;
            ready_out <= 1'b0;
            ready_oe_out <= 1'b0;
            sync_mode_out <= 1'b0;
            burst_active_out <= 1'b0;
        end else begin
            // Status replaces array data in a busy bank
            dq_out <= stat_d1 ? status_in : array_data_in; // RQ13
            dq_oe_out <= ce_on && oe_on &&
                (sync_mode ? (st != fbe_pkg::ST_IDLE) : async_sel); // RQ3
            // Ready only counts once OE is low
            ready_out <= rdy_d2 && oe_on; // RQ10 RQ20
            ready_oe_out <= ce_on && sync_mode;
            sync_mode_out <= sync_mode;
            burst_active_out <= (st != fbe_pkg::ST_IDLE);
        end
    end

    // Checks on the burst behaviour
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_data_edge;
        st == fbe_pkg::ST_DATA && act_edge && !load_hit && ce_on && next_ok;
    endsequence

    property p_async_at_reset;
        @(posedge clk_sys_in) disable iff (1'b0) !rst_n_in |=> !sync_mode;
    endproperty
    a_async_at_reset: assert property (p_async_at_reset) // RQ1
        else $error("sync mode set after reset");

    property p_no_async_in_sync;
        sync_mode && st == fbe_pkg::ST_IDLE && !cfg_load_in |=> !dq_oe_out;
    endproperty
    a_no_async_in_sync: assert property (p_no_async_in_sync) // RQ3
        else $error("data driven outside a burst in sync mode");

    property p_count_up;
        s_data_edge and cfg_mode == fbe_pkg::FBE_CONT |=>
            burst_addr == AW'($past(burst_addr) + 1'b1);
    endproperty
    a_count_up: assert property (p_count_up) // RQ4
        else $error("continuous burst address did not increment");

    property p_block_gap;
        s_data_edge and cfg_mode == fbe_pkg::FBE_CONT &&
            burst_addr[fbe_pkg::BLK_W-1:0] == 6'h3f && !(start_odd && first16_open) |=>
            st == fbe_pkg::ST_GAP && gap_cnt == (SLOW_VARIANT ? 2'h3 : 2'h2);
    endproperty
    a_block_gap: assert property (p_block_gap) // RQ6
        else $error("wrong gap at 64-word boundary");

    property p_gap_not_ready;
        st == fbe_pkg::ST_GAP && !cfg_rdy_early && ce_on |-> ##3 !ready_out;
    endproperty
    a_gap_not_ready: assert property (p_gap_not_ready) // RQ10
        else $error("ready high during boundary gap");

    property p_wrap8;
        s_data_edge and cfg_mode == fbe_pkg::FBE_WRAP8 && burst_addr[2:0] == 3'h7 |=>
            burst_addr[2:0] == 3'h0 && burst_addr[AW-1:3] == $past(burst_addr[AW-1:3]);
    endproperty
    a_wrap8: assert property (p_wrap8) // RQ16
        else $error("8-word wrap left its group");

    property p_wrap_no_gap;
        s_data_edge and cfg_mode != fbe_pkg::FBE_CONT |=> st == fbe_pkg::ST_DATA;
    endproperty
    a_wrap_no_gap: assert property (p_wrap_no_gap) // RQ17
        else $error("wrap mode inserted a wait");

    property p_status_hold;
        st == fbe_pkg::ST_STAT && ce_on && sync_mode && !load_hit && pin_rst_n |=>
            st == fbe_pkg::ST_STAT && $stable(burst_addr);
    endproperty
    a_status_hold: assert property (p_status_hold) // RQ13
        else $error("status state followed the clock");

    property p_pin_reset;
        !pin_rst_n |=> st == fbe_pkg::ST_IDLE && !sync_mode;
    endproperty
    a_pin_reset: assert property (p_pin_reset) // RQ26
        else $error("pin reset did not end the burst");

    property p_ce_stop;
        !ce_on |=> st == fbe_pkg::ST_IDLE && !dq_oe_out && !ready_oe_out;
    endproperty
    a_ce_stop: assert property (p_ce_stop) // RQ11
        else $error("burst continued with chip select high");
endmodule : fbe_burst_read

// >>> fbe_host_model.sv
// Host memory controller model driving the burst flash pins
`timescale 1ns/1ps
module fbe_host_model (
    // Clock and bench requests
    input wire logic clk_sys_in,
    input wire logic start_in,
    input wire logic [fbe_pkg::ADDR_W-1:0] req_addr_in,
    input wire logic [7:0] edges_in,
    input wire logic keep_ce_in,
    output logic done_out,
    // Flash pins
    output logic flash_clk_out,
    output logic chip_sel_n_out,
    output logic out_en_n_out,
    output logic write_en_n_out,
    output logic address_valid_n_out,
    output logic [fbe_pkg::ADDR_W-1:0] addr_out,
    input wire logic [fbe_pkg::DATA_W-1:0] dq_in,
    input wire logic dq_oe_in,
    input wire logic ready_in
);
    logic [fbe_pkg::DATA_W-1:0] smp_dat [0:63]; // Word seen before each edge
    logic smp_rdy [0:63]; // Ready seen before each edge
    initial begin
        {done_out, flash_clk_out, addr_out} = '0;
        {chip_sel_n_out, out_en_n_out, write_en_n_out, address_valid_n_out} = 4'hf;
    end
    // One request: burst of edges, or a single async read when zero
    always @(posedge clk_sys_in) begin
        if (start_in) begin
            chip_sel_n_out <= 1'b0;
            write_en_n_out <= 1'b1;
            out_en_n_out <= 1'b0;
            address_valid_n_out <= 1'b0;
            addr_out <= req_addr_in;
            repeat (4) @(posedge clk_sys_in);
            if (edges_in == 8'h0) begin
                address_valid_n_out <= 1'b1;
                addr_out <= ~req_addr_in; // Released bus never shows the old address
                repeat (10) @(posedge clk_sys_in);
                smp_dat[0] = dq_in;
                smp_rdy[0] = dq_oe_in;
            end
            // Link clock runs only inside the frame, 64 ns period
            for (int i = 0; i < edges_in; i++) begin
                smp_rdy[i] = ready_in;
                smp_dat[i] = dq_in;
                flash_clk_out <= 1'b1;
                repeat (4) @(posedge clk_sys_in);
                flash_clk_out <= 1'b0;
                address_valid_n_out <= 1'b1;
                addr_out <= ~req_addr_in;
                repeat (4) @(posedge clk_sys_in);
            end
            if (!keep_ce_in) begin
                {chip_sel_n_out, out_en_n_out} <= 2'h3;
            end
            done_out <= 1'b1;
            @(posedge clk_sys_in);
            done_out <= 1'b0;
        end
    end
endmodule : fbe_host_model

// >>> test_fbe_burst_read.sv
// Self-checking bench for the flash burst read engine
`timescale 1ns/1ps
module test_fbe_burst_read;
    localparam bit SLOW = 1'b0; // Standard variant under test
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic flash_rst_n = 1'b1; // Bench stands in for the host reset pin
    logic start = 1'b0;
    logic keep = 1'b0;
    logic [7:0] edges = 8'h0;
    logic [22:0] req = '0;
    logic done, fclk, ce_n, oe_n, we_n, avd_n, dq_oe, rdy, rdy_oe, sync_mode, active;
    logic [22:0] addr, array_addr;
    logic [15:0] dq;
    logic [15:0] array_data = '0;
    logic [15:0] status = 16'h00a5;
    logic cfg_load = 1'b0;
    logic [3:0] cfg_wait = 4'h0;
    logic [1:0] cfg_mode = 2'h0;
    logic [3:0] busy = 4'h0, susp = 4'h0;
    logic [22:0] corner [4] = '{23'h00003c, 23'h000011, 23'h000035, 23'h7ffffd};
    int err_count = 0;
    int samples_checked = 0;
    int seed = 32'hde08;
    int cycles = 0;
    int lead_a, lead_b;
    logic [22:0] a;
    // Clock, 8 ns period
    initial begin
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    fbe_host_model host (.clk_sys_in(clk_sys_in), .start_in(start), .req_addr_in(req),
        .edges_in(edges), .keep_ce_in(keep), .done_out(done), .flash_clk_out(fclk),
        .chip_sel_n_out(ce_n), .out_en_n_out(oe_n), .write_en_n_out(we_n),
        .address_valid_n_out(avd_n), .addr_out(addr), .dq_in(dq), .dq_oe_in(dq_oe),
        .ready_in(rdy));
    fbe_burst_read #(.SLOW_VARIANT(SLOW), .NBANK(4)) uut (.clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in), .flash_clk_in(fclk), .chip_sel_n_in(ce_n), .out_en_n_in(oe_n),
        .write_en_n_in(we_n), .address_valid_n_in(avd_n), .flash_rst_n_in(flash_rst_n),
        .addr_in(addr), .dq_out(dq), .dq_oe_out(dq_oe), .ready_out(rdy),
        .ready_oe_out(rdy_oe), .cfg_load_in(cfg_load), .cfg_wait_in(cfg_wait),
        .cfg_mode_in(cfg_mode), .cfg_falling_in(1'b0), .cfg_rdy_early_in(1'b0),
        .cfg_sync_en_in(1'b1), .array_addr_out(array_addr), .array_data_in(array_data),
        .bank_busy_in(busy), .bank_susp_in(susp), .susp_sector_in(8'h00),
        .status_in(status), .sync_mode_out(sync_mode), .burst_active_out(active));
    // Array word made from its address, one cycle latency
    function automatic logic [15:0] word(input logic [22:0] w);
        return w[15:0] ^ {w[22:16], 9'h000};
    endfunction : word
    always @(posedge clk_sys_in) begin
        array_data <= word(array_addr);
    end
    // Hang guard
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Configuration pulse, then let the fields settle
    task automatic cfg(input logic [3:0] w, input logic [1:0] m);
        cfg_wait <= w;
        cfg_mode <= m;
        cfg_load <= 1'b1;
        @(posedge clk_sys_in);
        cfg_load <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
    endtask : cfg
    // One request to the host model
    task automatic run(input logic [22:0] ra, input logic [7:0] n, input logic k);
        req <= ra;
        edges <= n;
        keep <= k;
        start <= 1'b1;
        @(posedge clk_sys_in);
        start <= 1'b0;
        while (done !== 1'b1) @(posedge clk_sys_in);
        repeat (8) @(posedge clk_sys_in);
    endtask : run
    // Expected burst, gaps included
    task automatic verify(input logic [22:0] sa, input logic [1:0] m, input int n,
        output int lead);
        logic [22:0] cur;
        logic [4:0] msk;
        logic open16;
        int gap;
        cur = sa;
        open16 = 1'b1;
        gap = 0;
        lead = 0;
        msk = (m == 2'h1) ? 5'h07 : (m == 2'h2) ? 5'h0f : 5'h1f;
        while (lead < n && host.smp_rdy[lead] !== 1'b1) lead++;
        for (int j = lead; j < n; j++) begin
            if (gap > 0) begin
                check(host.smp_rdy[j], 1'b0);
                gap--;
            end else begin
                check({host.smp_rdy[j], host.smp_dat[j]}, {1'b1, word(cur)});
                if (m != 2'h0) begin
                    cur[4:0] = (cur[4:0] & ~msk) | ((cur[4:0] + 5'h01) & msk);
                end else begin
                    if (cur[5:0] == 6'h3f) begin
                        gap = (sa[0] && open16) ? 3 : (SLOW ? 3 : 2);
                    end else if (cur[3:0] == 4'hf && sa[0] && open16) begin
                        gap = 1;
                    end
                    if (cur[3:0] == 4'hf) open16 = 1'b0;
                    cur = cur + 23'h000001;
                end
            end
        end
    endtask : verify
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        check(sync_mode, 1'b0);
        run(23'h000123, 8'h00, 1'b0);
        check({host.smp_rdy[0], host.smp_dat[0]}, {1'b1, word(23'h000123)});
        cfg(4'h2, 2'h0);
        check(sync_mode, 1'b1);
        run(23'h000123, 8'h00, 1'b0);
        check(host.smp_rdy[0], 1'b0);
        // Boundary corners in continuous mode, CE ends each burst
        foreach (corner[i]) begin
            run(corner[i], 8'd40, 1'b0);
            verify(corner[i], 2'h0, 40, lead_a);
            check(active, 1'b0);
        end
        // Initial delay follows the programmed wait count
        cfg(4'h6, 2'h0);
        run(23'h00003c, 8'd16, 1'b0);
        verify(23'h00003c, 2'h0, 16, lead_b);
        check(lead_b - lead_a, 4);
        cfg(4'h2, 2'h0);
        // Crossing into a busy bank shows status and ignores the clock
        busy <= 4'h2;
        status <= 16'h5a3c;
        run(23'h1ffffc, 8'd16, 1'b0);
        check(host.smp_dat[14], 16'h5a3c);
        check(host.smp_dat[15], 16'h5a3c);
        susp <= 4'h2;
        run(23'h200000, 8'd24, 1'b0);
        verify(23'h200000, 2'h0, 24, lead_a);
        // Random starts in every mode while bank three is busy
        busy <= 4'h8;
        for (int m = 0; m < 4; m++) begin
            cfg(4'h2, m[1:0]);
            a = $random(seed) & 23'h3fffff;
            run(a, 8'd32, 1'b0);
            verify(a, m[1:0], 32, lead_a);
        end
        cfg(4'h2, 2'h1);
        run(23'h000039, 8'd20, 1'b0);
        verify(23'h000039, 2'h1, 20, lead_a);
        // Pin reset in mid-burst returns to async reads
        run(23'h000040, 8'd8, 1'b1);
        check({active, rdy_oe}, 2'h3);
        flash_rst_n <= 1'b0;
        repeat (6) @(posedge clk_sys_in);
        flash_rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        check({active, sync_mode, rdy_oe}, 3'h0);
        run(23'h000456, 8'h00, 1'b0);
        check({host.smp_rdy[0], host.smp_dat[0]}, {1'b1, word(23'h000456)});
        results();
    end
endmodule : test_fbe_burst_read
